// ===== hw/touch_sense_global_tracking_config.sv
// Global settings, halt timer, tuning gate, baseline tracking and event blocking for eight channels.
// Assumes channel counts and states arrive on core_clk, qualified by sampleValid.
module touch_sense_global_tracking_config #(
	parameter int MS_TICK_CYCLES = touch_cfg_pkg::MS_TICK_CYC,
	parameter int NUM_CH         = 8
) (
	input  wire logic                                    core_clk,
	input  wire logic                                    rst_n,
	input  wire touch_cfg_pkg::reg_req_t                 regReq,
	output logic [15:0]                                  regRdData,
	input  wire logic                                    sampleValid,
	input  wire touch_cfg_pkg::chan_in_t [NUM_CH-1:0]    chanIn,
	input  wire logic [NUM_CH-1:0]                       reseedEnable,
	input  wire logic [7:0]                              haltSetting,
	input  wire logic                                    lowPowerMode,
	input  wire logic [15:0]                             tuneTarget,
	input  wire logic [15:0]                             threshold,
	output logic [NUM_CH-1:0][15:0]                      ltaOut,
	output logic [NUM_CH-1:0][15:0]                      countOut,
	output logic [NUM_CH-1:0]                            triggerOut,
	output logic [NUM_CH-1:0]                            eventReport,
	output logic [NUM_CH-1:0]                            tuneRequest,
	output logic                                         touchPinOut,
	output logic                                         touchPinOeN,
	output logic                                         txStrobe,
	output logic [NUM_CH-1:0][2:0]                       calCapHalfPf
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [15:0] absDiff(input logic [15:0] a, input logic [15:0] b);
		absDiff = (a > b) ? a - b : b - a;
	endfunction

	function automatic logic [15:0] ltaStep(input logic [15:0] base, input logic [15:0] cnt);
		ltaStep = (cnt > base) ? base + ((cnt - base) >> touch_cfg_pkg::LTA_SHIFT)
		                       : base - ((base - cnt) >> touch_cfg_pkg::LTA_SHIFT);
	endfunction

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [15:0] general_r;
	logic [15:0] reference_r;
	logic [15:0] blocking_r;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			general_r   <= touch_cfg_pkg::RST_GENERAL;
			reference_r <= touch_cfg_pkg::RST_REFERENCE;
			blocking_r  <= touch_cfg_pkg::RST_BLOCKING;
		end else if (regReq.wrEn) begin
			unique case (regReq.addr)
				touch_cfg_pkg::ADDR_GENERAL_SETTINGS_WORD: general_r <= regReq.wrData & touch_cfg_pkg::MASK_GENERAL;
				touch_cfg_pkg::ADDR_REFERENCE_CHANNEL: reference_r <= regReq.wrData & touch_cfg_pkg::MASK_REFERENCE;
				touch_cfg_pkg::ADDR_EVENT_BLOCKING: blocking_r <= regReq.wrData & touch_cfg_pkg::MASK_BLOCKING;
				default: ;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			regRdData <= 16'h0000;
		end else if (regReq.rdEn) begin
			unique case (regReq.addr)
				touch_cfg_pkg::ADDR_GENERAL_SETTINGS_WORD: regRdData <= general_r;
				touch_cfg_pkg::ADDR_REFERENCE_CHANNEL: regRdData <= reference_r;
				touch_cfg_pkg::ADDR_EVENT_BLOCKING: regRdData <= blocking_r;
				default: regRdData <= 16'h0000;
			endcase
		end
	end

	logic       bandCheckDis;
	logic       tuneLpOnly;
	logic       bandSel;
	logic       filterDis;
	logic [2:0] touchSel;
	logic       twoSided;
	logic [1:0] txDiv;
	logic       globalCap;
	logic [1:0] reseedLevel;
	logic       trackEn;

	assign bandCheckDis = general_r[touch_cfg_pkg::BIT_BAND_CHECK_DIS];
	assign tuneLpOnly   = general_r[touch_cfg_pkg::BIT_TUNE_LP_ONLY];
	assign bandSel      = general_r[touch_cfg_pkg::BIT_BAND_SELECT];
	assign filterDis    = general_r[touch_cfg_pkg::BIT_FILTER_DIS];
	assign touchSel     = general_r[touch_cfg_pkg::POS_TOUCH_SEL +: 3];
	assign twoSided     = general_r[touch_cfg_pkg::BIT_TWO_SIDED];
	assign txDiv        = general_r[touch_cfg_pkg::POS_TX_DIV +: 2];
	assign globalCap    = general_r[touch_cfg_pkg::BIT_GLOBAL_CAP];
	assign reseedLevel  = reference_r[touch_cfg_pkg::POS_RESEED_LEVEL +: 2];
	assign trackEn      = reference_r[touch_cfg_pkg::BIT_TRACK_EN];

	// ----------------------------------------------------------------
	// Channel events
	// ----------------------------------------------------------------
	logic [NUM_CH-1:0][1:0] prevState_r;
	logic [NUM_CH-1:0]      stateChg;
	logic [NUM_CH-1:0]      refRise;
	logic [NUM_CH-1:0]      assocOk;
	logic [NUM_CH-1:0]      refHalted;
	logic                   anyReseedEvent;

	always_comb begin
		refHalted = '0;
		for (int i = 0; i < NUM_CH; i++) begin
			stateChg[i] = sampleValid && (chanIn[i].state != prevState_r[i]);
			refRise[i]  = sampleValid && (prevState_r[i] == touch_cfg_pkg::ST_NONE)
			              && (chanIn[i].state != touch_cfg_pkg::ST_NONE);
			assocOk[i]  = chanIn[i].isAssoc && (chanIn[i].refSel != i[2:0]);
		end
		for (int i = 0; i < NUM_CH; i++) begin
			if (trackEn && assocOk[i] && chanIn[i].state != touch_cfg_pkg::ST_NONE) begin
				refHalted[chanIn[i].refSel] = 1'b1;
			end
		end
		anyReseedEvent = |(stateChg & reseedEnable);
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			prevState_r <= '0;
		end else if (sampleValid) begin
			for (int i = 0; i < NUM_CH; i++) begin
				prevState_r[i] <= chanIn[i].state;
			end
		end
	end

	// ----------------------------------------------------------------
	// Halt timer
	// ----------------------------------------------------------------
	logic [15:0] msCnt_r;
	logic        msTick;
	logic [16:0] haltMs_r;
	logic [16:0] haltLimit;
	logic        haltExpire;

	assign msTick     = (msCnt_r == 16'(MS_TICK_CYCLES - 1));
	assign haltLimit  = {haltSetting, 9'h000};
	assign haltExpire = msTick && (haltSetting != touch_cfg_pkg::HALT_NEVER)
	                    && !anyReseedEvent && (haltMs_r + 17'h00001 >= haltLimit);

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			msCnt_r <= 16'h0000;
		end else begin
			msCnt_r <= msTick ? 16'h0000 : msCnt_r + 16'h0001;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			haltMs_r <= 17'h00000;
		end else if (anyReseedEvent || haltExpire) begin
			haltMs_r <= 17'h00000;
		end else if (msTick && haltMs_r != 17'h1FFFF) begin
			haltMs_r <= haltMs_r + 17'h00001;
		end
	end

	// ----------------------------------------------------------------
	// Baseline, filter, tracking and triggers
	// ----------------------------------------------------------------
	logic [NUM_CH-1:0][15:0] base_r;
	logic [NUM_CH-1:0]       reseedNow;

	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			reseedNow[i] = (haltExpire && reseedEnable[i])
			               || (!trackEn && assocOk[i] && refRise[chanIn[i].refSel]
			                   && chanIn[i].state <= reseedLevel);
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			base_r <= '0;
		end else begin
			for (int i = 0; i < NUM_CH; i++) begin
				if (reseedNow[i]) begin
					base_r[i] <= chanIn[i].count;
				end else if (sampleValid && !refHalted[i]) begin
					if (twoSided) begin
						if (absDiff(chanIn[i].count, base_r[i]) <= threshold) begin
							base_r[i] <= ltaStep(base_r[i], chanIn[i].count);
						end
					end else if (chanIn[i].count > base_r[i]) begin
						base_r[i] <= ltaStep(base_r[i], chanIn[i].count);
					end
				end
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		logic signed [16:0] delta;
		logic [7:0]         w;
		logic signed [25:0] prod;
		if (!rst_n) begin
			ltaOut <= '0;
		end else begin
			for (int i = 0; i < NUM_CH; i++) begin
				delta = 17'(base_r[chanIn[i].refSel]) - 17'(chanIn[chanIn[i].refSel].count);
				w     = (chanIn[i].weightPct > touch_cfg_pkg::WEIGHT_MAX_PCT) ?
				        touch_cfg_pkg::WEIGHT_MAX_PCT : chanIn[i].weightPct;
				prod  = delta * $signed({1'b0, w}) / $signed({1'b0, touch_cfg_pkg::PCT_DIVISOR});
				if (trackEn && assocOk[i] && chanIn[i].state != touch_cfg_pkg::ST_NONE) begin
					ltaOut[i] <= base_r[i] - prod[15:0];
				end else begin
					ltaOut[i] <= base_r[i];
				end
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			countOut <= '0;
		end else if (sampleValid) begin
			for (int i = 0; i < NUM_CH; i++) begin
				if (filterDis) begin
					countOut[i] <= chanIn[i].count;
				end else begin
					countOut[i] <= ltaStep(countOut[i], chanIn[i].count); // Filter shares the average step
				end
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			triggerOut <= '0;
		end else if (sampleValid) begin
			for (int i = 0; i < NUM_CH; i++) begin
				triggerOut[i] <= ((base_r[i] > chanIn[i].count) || twoSided)
				                 && absDiff(base_r[i], chanIn[i].count) > threshold;
			end
		end
	end

	// ----------------------------------------------------------------
	// Event blocking
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		logic [2:0] b;
		if (!rst_n) begin
			eventReport <= '0;
		end else begin
			for (int i = 0; i < NUM_CH; i++) begin
				b = chanIn[i].refSel;
				if (assocOk[i] && blocking_r[b]) begin
					eventReport[i] <= (stateChg[i] && !stateChg[b] && chanIn[b].state == touch_cfg_pkg::ST_NONE)
					                  || (!stateChg[i] && stateChg[b] && chanIn[i].state != touch_cfg_pkg::ST_NONE);
				end else begin
					eventReport[i] <= stateChg[i];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Tuning gate
	// ----------------------------------------------------------------
	logic [15:0] bandWidth;
	assign bandWidth = bandSel ? (tuneTarget >> 4) : (tuneTarget >> 3);

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tuneRequest <= '0;
		end else begin
			for (int i = 0; i < NUM_CH; i++) begin
				tuneRequest[i] <= sampleValid && !bandCheckDis
				                  && (!tuneLpOnly || lowPowerMode)
				                  && absDiff(chanIn[i].count, tuneTarget) > bandWidth;
			end
		end
	end

	// ----------------------------------------------------------------
	// Touch pin, transmit divider, calibration capacitor
	// ----------------------------------------------------------------
	logic [2:0] txCnt_r;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			touchPinOut <= 1'b1;
			touchPinOeN <= 1'b1;
		end else begin
			touchPinOut <= 1'b0;
			touchPinOeN <= !(chanIn[touchSel].state >= touch_cfg_pkg::ST_TOUCH);
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			txCnt_r  <= 3'h0;
			txStrobe <= 1'b0;
		end else begin
			txStrobe <= ((txCnt_r & ((3'h1 << txDiv) - 3'h1)) == 3'h0);
			txCnt_r  <= txCnt_r + 3'h1;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			calCapHalfPf <= '0;
		end else begin
			for (int i = 0; i < NUM_CH; i++) begin
				calCapHalfPf[i] <= chanIn[i].capEn ? ((globalCap ? 3'h3 : 3'h1) + {2'h0, chanIn[i].capExtra}) : 3'h0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	property p_haltNever;
		haltSetting == touch_cfg_pkg::HALT_NEVER |-> !haltExpire;
	endproperty
	a_haltNever: assert property (p_haltNever) else $error("halt expired while disabled");

	property p_reseedCopies;
		haltExpire && reseedEnable[0] |=> base_r[0] == $past(chanIn[0].count);
	endproperty
	a_reseedCopies: assert property (p_reseedCopies) else $error("reseed did not copy count");

	property p_restart;
		anyReseedEvent |=> haltMs_r == 17'h00000;
	endproperty
	a_restart: assert property (p_restart) else $error("halt timer not restarted");

	property p_filterBypass;
		sampleValid && filterDis |=> countOut[0] == $past(chanIn[0].count);
	endproperty
	a_filterBypass: assert property (p_filterBypass) else $error("raw count not passed");

	property p_tuneLp;
		tuneLpOnly && !lowPowerMode |=> tuneRequest == '0;
	endproperty
	a_tuneLp: assert property (p_tuneLp) else $error("tuning outside low power");

	property p_bandDis;
		bandCheckDis |=> tuneRequest == '0;
	endproperty
	a_bandDis: assert property (p_bandDis) else $error("tuning with band check off");

	logic selTouchNow;
	assign selTouchNow = chanIn[touchSel].state >= touch_cfg_pkg::ST_TOUCH;

	property p_touchPin;
		1'b1 |=> touchPinOeN == !$past(selTouchNow);
	endproperty
	a_touchPin: assert property (p_touchPin) else $error("touch pin wrong channel");

	property p_oneSidedFreeze;
		sampleValid && !twoSided && !reseedNow[0] && chanIn[0].count < base_r[0] |=> $stable(base_r[0]);
	endproperty
	a_oneSidedFreeze: assert property (p_oneSidedFreeze) else $error("average moved down");

	property p_trackNoReseed;
		trackEn && !haltExpire |-> reseedNow == '0;
	endproperty
	a_trackNoReseed: assert property (p_trackNoReseed) else $error("reference reseed while tracking");

	property p_divEight;
		(txDiv == 2'h3 && $stable(txDiv) && txStrobe) ##1 (txDiv == 2'h3) |-> !txStrobe [*7];
	endproperty
	a_divEight: assert property (p_divEight) else $error("divide by eight spacing");

	c_haltExpire:  cover property (haltExpire);
	c_refReseed:   cover property (!trackEn && |reseedNow && !haltExpire);
	c_tracking:    cover property (|refHalted);
	c_blockedEvent: cover property (|stateChg && eventReport == '0);

endmodule

// ===== hw/touch_cfg_pkg.sv
// Constants and carrier types for the global configuration and tracking block.
// Assumes one 10 MHz core clock; all channel inputs come from logic on that clock.
package touch_cfg_pkg;

	// ----------------------------------------------------------------
	// Register map and field layout
	// ----------------------------------------------------------------
	localparam logic [7:0]  ADDR_GENERAL_SETTINGS_WORD = 8'h86;
	localparam logic [7:0]  ADDR_REFERENCE_CHANNEL     = 8'h87;
	localparam logic [7:0]  ADDR_EVENT_BLOCKING        = 8'h88;
	localparam logic [15:0] MASK_GENERAL               = 16'h71F7;
	localparam logic [15:0] MASK_REFERENCE             = 16'hE000;
	localparam logic [15:0] MASK_BLOCKING              = 16'h00FF;
	localparam logic [15:0] RST_GENERAL                = 16'h0000;
	localparam logic [15:0] RST_REFERENCE              = 16'h0000;
	localparam logic [15:0] RST_BLOCKING               = 16'h0000;
	localparam int BIT_BAND_CHECK_DIS = 7;
	localparam int BIT_TUNE_LP_ONLY   = 6;
	localparam int BIT_BAND_SELECT    = 5;
	localparam int BIT_FILTER_DIS     = 4;
	localparam int POS_TOUCH_SEL      = 0;
	localparam int BIT_TWO_SIDED      = 14;
	localparam int POS_TX_DIV         = 12;
	localparam int BIT_GLOBAL_CAP     = 8;
	localparam int POS_RESEED_LEVEL   = 14;
	localparam int BIT_TRACK_EN       = 13;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam int MS_TICK_NS    = 1000000;
	localparam int MS_TICK_CYC   = MS_TICK_NS / CLK_PERIOD_NS;
	localparam int HALT_STEP_MS  = 512;
	localparam logic [7:0] HALT_NEVER = 8'hFF;

	// ----------------------------------------------------------------
	// Arithmetic constants
	// ----------------------------------------------------------------
	localparam int LTA_SHIFT      = 4;
	localparam int FILTER_SHIFT   = 2;
	localparam logic [7:0]  WEIGHT_MAX_PCT = 8'hC8;
	localparam logic [24:0] PCT_DIVISOR    = 25'h0000064;

	// Channel condition codes, ordered by level
	localparam logic [1:0] ST_NONE  = 2'h0;
	localparam logic [1:0] ST_PROX  = 2'h1;
	localparam logic [1:0] ST_TOUCH = 2'h2;
	localparam logic [1:0] ST_DEEP  = 2'h3;

	typedef struct packed {
		logic [15:0] count;
		logic [1:0]  state;
		logic [2:0]  refSel;
		logic        isAssoc;
		logic [7:0]  weightPct;
		logic        capEn;
		logic        capExtra;
	} chan_in_t;

	typedef struct packed {
		logic        wrEn;
		logic        rdEn;
		logic [7:0]  addr;
		logic [15:0] wrData;
	} reg_req_t;

endpackage

// ===== verif/reg_host.sv
// Host-side register master for the configuration block.
// Assumes regRdData answers one cycle after a read strobe.
module reg_host (
	input  wire logic               core_clk,
	input  wire logic [15:0]        regRdData,
	output touch_cfg_pkg::reg_req_t regReq
);
	timeunit 1ns;
	timeprecision 1ns;

	initial regReq = '0;

	// ----------------------------------------------------------------
	// Bus cycle: strobe for one edge, take read data at that edge
	// ----------------------------------------------------------------
	task automatic access(input logic wr, input logic [7:0] a, input logic [15:0] d, output logic [15:0] q);
		@(posedge core_clk);
		#1;
		regReq = '{wrEn: wr, rdEn: !wr, addr: a, wrData: d};
		@(posedge core_clk);
		#1;
		q = regRdData;
		regReq = '0;
	endtask
endmodule

// ===== verif/tb_top.sv
// Self-checking bench for the global configuration and tracking block.
// Assumes the design answers per its hand-over timing; ms tick shortened.
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int TICK = 4;
	localparam logic [7:0]  ADDRS [3] = '{8'h86, 8'h87, 8'h88};
	localparam logic [15:0] MASKS [3] = '{16'h71F7, 16'hE000, 16'h00FF};

	logic                              core_clk = 0;
	logic                              rst_n = 0;
	touch_cfg_pkg::reg_req_t           regReq;
	logic [15:0]                       regRdData;
	logic                              sampleValid = 0;
	touch_cfg_pkg::chan_in_t [7:0]     chanIn = '0;
	logic [7:0]                        reseedEnable = 8'hFF;
	logic [7:0]                        haltSetting = 8'hFF;
	logic                              lowPowerMode = 0;
	logic [15:0]                       tuneTarget = 16'h0320;
	logic [15:0]                       threshold = 16'h0040;
	logic [7:0][15:0]                  ltaOut;
	logic [7:0][15:0]                  countOut;
	logic [7:0]                        triggerOut;
	logic [7:0]                        eventReport;
	logic [7:0]                        tuneRequest;
	logic                              touchPinOut;
	logic                              touchPinOeN;
	logic                              txStrobe;
	logic [7:0][2:0]                   calCapHalfPf;
	logic [15:0]                       shadow [3] = '{16'h0000, 16'h0000, 16'h0000};
	int                                num_errors = 0;
	int                                tests_run = 0;

	always #50 core_clk = ~core_clk;

	reg_host host (.core_clk(core_clk), .regRdData(regRdData), .regReq(regReq));

	touch_sense_global_tracking_config #(.MS_TICK_CYCLES(TICK), .NUM_CH(8)) uut (
		.core_clk(core_clk), .rst_n(rst_n), .regReq(regReq), .regRdData(regRdData),
		.sampleValid(sampleValid), .chanIn(chanIn), .reseedEnable(reseedEnable),
		.haltSetting(haltSetting), .lowPowerMode(lowPowerMode), .tuneTarget(tuneTarget),
		.threshold(threshold), .ltaOut(ltaOut), .countOut(countOut), .triggerOut(triggerOut),
		.eventReport(eventReport), .tuneRequest(tuneRequest), .touchPinOut(touchPinOut),
		.touchPinOeN(touchPinOeN), .txStrobe(txStrobe), .calCapHalfPf(calCapHalfPf)
	);

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test;
		if (num_errors == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic wr(input int k, input logic [15:0] d);
		logic [15:0] q;
		host.access(1, ADDRS[k], d, q);
		shadow[k] = d & MASKS[k];
	endtask

	task automatic rd_check(input int k);
		logic [15:0] q;
		host.access(0, ADDRS[k], 16'h0000, q);
		check(q, shadow[k]);
	endtask

	// Channels in hot take state st, the rest none
	task automatic sample(input logic [15:0] c, input logic [7:0] hot, input logic [1:0] st);
		for (int i = 0; i < 8; i++) begin
			chanIn[i].count = c;
			chanIn[i].state = hot[i] ? st : touch_cfg_pkg::ST_NONE;
		end
		sampleValid = 1;
		@(posedge core_clk);
		#1;
		sampleValid = 0;
	endtask

	task automatic wait_strobe(output int n);
		n = 0;
		do begin
			@(posedge core_clk);
			#1;
			n++;
		end while (txStrobe !== 1'b1 && n < 20);
		if (txStrobe !== 1'b1) begin
			num_errors++;
		end
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [15:0] q;
		int n;
		int w;
		logic [15:0] tab [6][4];
		void'($urandom(32653));
		repeat (4) @(posedge core_clk);
		#1;
		check({touchPinOut, touchPinOeN}, 16'h0003);
		rst_n = 1;
		for (int k = 0; k < 3; k++) rd_check(k);
		for (int r = 0; r < 4; r++) begin
			for (int k = 0; k < 3; k++) begin
				wr(k, 16'($urandom()));
				rd_check(k);
			end
		end
		host.access(1, 8'h89, 16'hFFFF, q);
		host.access(0, 8'h89, 16'h0000, q);
		check(q, 16'h0000);
		for (int k = 0; k < 3; k++) rd_check(k);
		wr(1, 16'h0000);
		wr(2, 16'h0000);
		for (int s = 0; s < 8; s++) begin
			wr(0, 16'h0010 | 16'(s));
			sample(16'h0100, 8'h01 << s, touch_cfg_pkg::ST_TOUCH);
			repeat (2) @(posedge core_clk);
			#1;
			check({touchPinOut, touchPinOeN}, 16'h0000);
			sample(16'h0100, ~(8'h01 << s), touch_cfg_pkg::ST_TOUCH);
			repeat (2) @(posedge core_clk);
			#1;
			check({touchPinOut, touchPinOeN}, 16'h0001);
		end
		for (int c = 0; c < 4; c++) begin
			wr(0, 16'h0010 | 16'(c << 12));
			wait_strobe(n);
			wait_strobe(n);
			check(16'(n), 16'(1 << c));
		end
		for (int g = 0; g < 2; g++) begin
			for (int e = 0; e < 2; e++) begin
				for (int i = 0; i < 8; i++) begin
					chanIn[i].capEn = !i[0];
					chanIn[i].capExtra = e[0];
				end
				wr(0, 16'h0010 | 16'(g << 8));
				repeat (2) @(posedge core_clk);
				#1;
				for (int i = 0; i < 8; i++) check(16'(calCapHalfPf[i]), i[0] ? 16'h0 : 16'(1 + 2 * g + e));
			end
		end
		// Control word, low-power level, count, expected request
		tab = '{'{16'h0010, 1, 16'h035C, 0}, '{16'h0030, 1, 16'h035C, 16'h00FF},
			'{16'h0010, 1, 16'h03B6, 16'h00FF}, '{16'h0090, 1, 16'h03B6, 0},
			'{16'h0050, 0, 16'h03B6, 0}, '{16'h0050, 1, 16'h03B6, 16'h00FF}};
		for (int t = 0; t < 6; t++) begin
			wr(0, tab[t][0]);
			lowPowerMode = tab[t][1][0];
			sample(tab[t][2], 8'h00, touch_cfg_pkg::ST_NONE);
			check(16'(tuneRequest), tab[t][3]);
			check(countOut[3], tab[t][2]);
		end
		wr(0, 16'h0000);
		sample(16'h1000, 8'h00, touch_cfg_pkg::ST_NONE);
		check(countOut[3], 16'h047A);
		wr(0, 16'h0010);
		sample(16'h2000, 8'hFF, touch_cfg_pkg::ST_PROX);
		sample(16'h2000, 8'h00, touch_cfg_pkg::ST_NONE);
		repeat (2600) @(posedge core_clk);
		#1;
		check(16'(ltaOut[0] === 16'h2000), 16'h0000);
		haltSetting = 8'h01;
		for (int p = 0; p < 2; p++) begin
			sample(16'h2000, 8'hFF, touch_cfg_pkg::ST_PROX);
			sample(16'h2000, 8'h00, touch_cfg_pkg::ST_NONE);
			repeat (1000) @(posedge core_clk);
			#1;
		end
		repeat (900) @(posedge core_clk);
		#1;
		check(16'(ltaOut[0] === 16'h2000), 16'h0000);
		w = 0;
		while (ltaOut[7] !== 16'h2000 && w < 400) begin
			@(posedge core_clk);
			#1;
			w++;
		end
		check(16'(w < 400), 16'h0001);
		for (int i = 0; i < 8; i++) check(ltaOut[i], 16'h2000);
		// Trigger direction, one- and two-sided
		haltSetting = 8'hFF;
		sample(16'h1F00, 8'h00, touch_cfg_pkg::ST_NONE);
		check(16'(triggerOut), 16'h00FF);
		sample(16'h2100, 8'h00, touch_cfg_pkg::ST_NONE);
		check(16'(triggerOut), 16'h0000);
		wr(0, 16'h4010);
		sample(16'h2200, 8'h00, touch_cfg_pkg::ST_NONE);
		check(16'(triggerOut), 16'h00FF);
		@(posedge core_clk);
		#1;
		check(ltaOut[2], 16'h2010);
		// Channel 1 associated with channel 0, which blocks its events
		wr(0, 16'h0010);
		wr(2, 16'h0001);
		chanIn[1].isAssoc = 1;
		chanIn[1].refSel = 3'h0;
		sample(16'h1000, 8'h01, touch_cfg_pkg::ST_PROX);
		check(16'(eventReport), 16'h0001);
		@(posedge core_clk);
		#1;
		check(ltaOut[1], 16'h1000);
		check(ltaOut[2], 16'h2010);
		sample(16'h1000, 8'h03, touch_cfg_pkg::ST_PROX);
		check(16'(eventReport), 16'h0000);
		for (int v = 0; v < 2; v++) begin
			wr(1, 16'(v << 14));
			sample(16'h0800, 8'h02, touch_cfg_pkg::ST_PROX);
			sample(16'h0800, 8'h03, touch_cfg_pkg::ST_PROX);
			@(posedge core_clk);
			#1;
			check(ltaOut[1], v ? 16'h0800 : 16'h1000);
		end
		// Tracking: reference delta 0x10, weights 100 and clamped 255
		wr(1, 16'h2000);
		chanIn[0].count = 16'h2000;
		chanIn[2].isAssoc = 1;
		chanIn[2].weightPct = 8'h64;
		for (int v = 0; v < 2; v++) begin
			chanIn[1].weightPct = v ? 8'hFF : 8'h64;
			repeat (2) @(posedge core_clk);
			#1;
			check(ltaOut[1], v ? 16'h07E0 : 16'h07F0);
		end
		check(ltaOut[2], 16'h2010);
		// Reset in mid-run clears the registers
		rst_n = 0;
		@(posedge core_clk);
		#1;
		rst_n = 1;
		for (int k = 0; k < 3; k++) begin
			shadow[k] = 16'h0000;
			rd_check(k);
		end
		end_of_test();
	end
endmodule
